// *** core/cps_sequencer.sv ***
/*
  Command interpreter and payout sequencer of a coin dispensing unit.
  Assumes: frame bytes arrive one per rxValid pulse, replies leave under
  txValid/txReady, coin exit, opto, overcurrent and low-supply inputs are
  synchronous levels or pulses.
*/
`timescale 1ns/1ps
// Functional notes
// R1 - Test query answers two status bytes: disabled and pin lock state.
// R2 - Host sends pin code before enable or dispense when lock active.
// R3 - After reset host resends pin code since reset relocks unit.
// R4 - Enable command has one data byte; reply is bare acknowledge.
// R5 - Randomise command mixes eight host bytes into key, bare acknowledge.
// R6 - Key request returns exactly eight security bytes.
// R7 - Serial keyed units may skip randomise and key request.
// R8 - Cipher mode dispense: eight key bytes then coin count.
// R9 - Serial mode dispense: three serial bytes then coin count.
// R10 - Host picks dispense key from product configuration.
// R11 - Dispense reply holds event counter, bumped on every dispense command.
// R12 - Status query returns event, remaining, paid, unpaid.
// R13 - Host polls status during payout until remaining is zero.
// R14 - Test status flags payout timeout, opto blocking and jam.
// R15 - Host may verify totals via status and dispense count queries.
// R16 - Host resets on errors, then dispenses promptly after opto errors.
// R17 - Host resolves address clashes at start-up.
// R18 - Supply low for 20 ms aborts payout, saves counters, resets.
// R19 - Above trip level, a jam reverses then restarts the motor.
// R20 - Reversal starts after current over limit for 160 ms.
// R21 - Dispense during a running payout gets a negative acknowledge.
// R22 - Each coin decrements remaining and increments paid.
// R23 - Supply sampled once per millisecond.
// R24 - Frames carry addresses, length, header, data, zero-sum checksum.
// R25 - Dispense with wrong key is refused with negative acknowledge.
module cps_sequencer #(
  parameter int unsigned MS_CYCLES = cps_pkg::MS_TICK_CYC, // Clock cycles per ms
  parameter logic [7:0]  OWN_ADDR  = cps_pkg::DEV_ADDR     // Bus address
) (
  input  wire logic        clk,          // System clock
  input  wire logic        resetn,       // Sync reset, active low
  input  wire logic [7:0]  rxByte,       // Received frame byte
  input  wire logic        rxValid,      // Received byte strobe
  output logic      [7:0]  txByte,       // Reply byte
  output logic             txValid,      // Reply byte valid
  input  wire logic        txReady,      // Reply byte taken
  input  wire logic [1:0]  regAddr,      // Register index
  input  wire logic [31:0] regWdata,     // Register write data
  input  wire logic        regWr,        // Register write strobe
  input  wire logic        regRd,        // Register read strobe
  output logic      [31:0] regRdata,     // Read data, cycle after strobe
  input  wire logic        coinSeen,     // One pulse per coin leaving
  input  wire logic        optoBlocked,  // Coin exit opto blocked
  input  wire logic        overCurrent,  // Motor current above limit
  input  wire logic        supplyLow,    // Supply below supply_trip_level
  output logic             motorRun,     // Motor forward
  output logic             motorReverse, // Motor reverse
  output logic             saveReq       // Pulse: store counters
);
  import cps_pkg::*;
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_SUM} cps_tx_t;
  logic [31:0] ctrl, serialNo, pinCode, msCnt;
  logic [4:0]  rxIdx;
  logic [7:0]  rxSum, rxDest, rxLen, rxSrc, rxHdr, txSum, eventCnt, coinsLeft, coinsPaid, coinsUnpaid;
  logic [7:0]  rxData [0:MAX_DATA-1];
  logic [7:0]  txBuf [0:TX_MAX-1];
  logic [3:0]  txN, txPos;
  cps_tx_t     txState;
  logic [63:0] secKey;
  logic [23:0] lifeCnt;
  logic [8:0]  ocCnt, revCnt;
  logic [4:0]  pfCnt;
  logic [11:0] idleMs;
  logic        cmdGo, txStart, keyFetched, enabled, unlocked, payoutActive, resetOcc, msTick;
  logic        expiredFlag, blockageFlag, optoFlag, keyOk, dispOk, jamTrip, pfTrip, timeoutTrip;
  // Millisecond enable; all slow timers count this pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {msCnt, msTick} <= '0;
    end else begin
      msTick <= (msCnt == MS_CYCLES - 1);
      msCnt  <= (msCnt == MS_CYCLES - 1) ? '0 : msCnt + 32'd1;
    end
  end
  // Frame receiver: checksum over every byte must come to zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxIdx <= '0;
      rxSum <= '0;
      cmdGo <= 1'b0;
      {rxDest, rxLen, rxSrc, rxHdr} <= '0;
    end else begin
      cmdGo <= 1'b0;
      if (rxValid) begin
        rxSum <= rxSum + rxByte;
        rxIdx <= rxIdx + 5'd1;
        case (rxIdx)
          5'h00: rxDest <= rxByte;
          5'h01: rxLen  <= rxByte;
          5'h02: rxSrc  <= rxByte;
          5'h03: rxHdr  <= rxByte;
          default: ;
        endcase
        // Oversized frames resync at once rather than overrun the buffer
        if (rxIdx == 5'd2 && rxLen > 8'(MAX_DATA)) begin
          rxIdx <= '0;
          rxSum <= '0;
        end else if (rxIdx >= 5'd4 && {3'h0, rxIdx} == rxLen + 8'd4) begin
          rxIdx <= '0;
          rxSum <= '0;
          // Busy transmitter drops the frame; host retries on timeout
          cmdGo <= (8'(rxSum + rxByte) == 8'h00) && rxDest == OWN_ADDR && txState == TX_IDLE; // R24
        end
      end
    end
  end

  // Data bytes kept in place for the executor
  always_ff @(posedge clk) begin
    if (rxValid && rxIdx >= 5'd4 && rxIdx < 5'(HDR_BYTES + MAX_DATA))
      rxData[4'(rxIdx - 5'd4)] <= rxByte;
  end

  // Dispense key check per keying mode
  always_comb begin
    keyOk = 1'b0;
    case (cps_keymode_t'(ctrl[1:0]))
      KEY_CIPHER: begin
        keyOk = (rxLen == 8'd9) && keyFetched; // R8
        for (int i = 0; i < KEY_BYTES; i++)
          if (rxData[i] != (secKey[8*i +: 8] ^ CIPHER_MASK)) keyOk = 1'b0;
      end
      KEY_DUMMY:  keyOk = (rxLen == 8'd9) && keyFetched;
      KEY_SERIAL: keyOk = (rxLen == 8'd4) && {rxData[2], rxData[1], rxData[0]} == serialNo[23:0]; // R9
      default:    keyOk = 1'b0;
    endcase
    dispOk = keyOk && enabled && (unlocked || !ctrl[2]) && !payoutActive && !optoFlag; // R21 R25
  end

  // Command execution, payout counters and unit state
  always_ff @(posedge clk) begin : execP
    logic [3:0] rl;
    logic [7:0] rh;
    if (!resetn) begin
      txStart <= 1'b0;
      txN <= '0;
      secKey <= 64'h0123_4567_89AB_CDEF;
      {keyFetched, enabled, unlocked, payoutActive} <= '0;
      resetOcc <= 1'b1;
      {expiredFlag, blockageFlag, optoFlag} <= '0;
      {eventCnt, coinsLeft, coinsPaid, coinsUnpaid} <= '0;
      lifeCnt <= '0;
    end else begin
      txStart <= 1'b0;
      rl = 4'd0;
      rh = HDR_ACK;
      // Coin and abort events during the payout
      if (payoutActive && coinSeen) begin
        coinsLeft <= coinsLeft - 8'd1; // R22
        coinsPaid <= coinsPaid + 8'd1; // R22
        lifeCnt   <= lifeCnt + 24'd1;
        if (coinsLeft == 8'd1) payoutActive <= 1'b0;
      end else if (payoutActive && (timeoutTrip || pfTrip)) begin
        coinsUnpaid  <= coinsLeft;
        coinsLeft    <= '0;
        payoutActive <= 1'b0;
      end
      if (cmdGo) begin
        case (rxHdr)
          CMD_TEST: begin
            rl = 4'd2; // R1
            txBuf[4] <= {!enabled, 4'h0, optoFlag, blockageFlag, expiredFlag}; // R14
            txBuf[5] <= {ctrl[2] && !unlocked, 6'h0, resetOcc};
          end
          CMD_ENABLE: enabled <= (rxData[0] == ENABLE_CODE); // R4
          CMD_PIN: unlocked <= {rxData[3], rxData[2], rxData[1], rxData[0]} == pinCode;
          CMD_RANDOM: begin
            for (int i = 0; i < KEY_BYTES; i++) // R5
              secKey[8*i +: 8] <= {secKey[8*i +: 7], secKey[8*i+7] ^ secKey[63]} ^ rxData[i];
            keyFetched <= 1'b0;
          end
          CMD_KEY_REQ: begin
            rl = 4'd8; // R6
            for (int i = 0; i < KEY_BYTES; i++)
              txBuf[HDR_BYTES + i] <= secKey[8*i +: 8];
            keyFetched <= 1'b1;
          end
          CMD_DISPENSE: begin
            eventCnt <= eventCnt + 8'd1; // R11
            rl = 4'd1;
            txBuf[4] <= eventCnt + 8'd1;
            if (dispOk && rxData[4'(rxLen - 8'd1)] != 8'h00) begin
              coinsLeft    <= rxData[4'(rxLen - 8'd1)];
              coinsPaid    <= '0;
              coinsUnpaid  <= '0;
              payoutActive <= 1'b1;
              keyFetched   <= 1'b0;
              {expiredFlag, blockageFlag} <= '0;
            end else if (!dispOk) begin
              rl = 4'd0;
              rh = HDR_NAK; // R21 R25
            end
          end
          CMD_STATUS: begin
            rl = 4'd4; // R12
            txBuf[4] <= eventCnt;
            txBuf[5] <= coinsLeft;
            txBuf[6] <= coinsPaid;
            txBuf[7] <= coinsUnpaid;
          end
          CMD_DISP_CNT: begin
            rl = 4'd3;
            {txBuf[6], txBuf[5], txBuf[4]} <= lifeCnt;
          end
          CMD_RESET: begin
            {enabled, unlocked, keyFetched, payoutActive} <= '0;
            {expiredFlag, blockageFlag, optoFlag} <= '0;
            coinsLeft <= '0;
            resetOcc  <= 1'b1;
          end
          default: rh = 8'hFF; // Unknown header: stay silent
        endcase
        if (rh != 8'hFF) begin
          txBuf[0] <= rxSrc; // R24
          txBuf[1] <= {4'h0, rl};
          txBuf[2] <= OWN_ADDR;
          txBuf[3] <= rh;
          txN      <= rl + 4'(HDR_BYTES);
          txStart  <= 1'b1;
        end
        if (rxHdr == CMD_ENABLE) resetOcc <= 1'b0;
      end
      // Power fail relocks and disables like a reset
      if (pfTrip) begin
        {enabled, unlocked, keyFetched} <= '0; // R18
        resetOcc <= 1'b1;
      end
      // Sticky error flags; a set in the clearing cycle wins
      if (timeoutTrip && payoutActive) expiredFlag <= 1'b1; // R14
      if (jamTrip) blockageFlag <= 1'b1;                    // R14
      if (optoBlocked) optoFlag <= 1'b1;                    // R14
    end
  end

  // Reply transmitter, checksum appended on the fly
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txState <= TX_IDLE;
      {txValid, txByte, txPos, txSum} <= '0;
    end else begin
      case (txState)
        TX_IDLE: if (txStart) begin
          txState <= TX_DATA;
          txValid <= 1'b1;
          txByte  <= txBuf[0];
          txSum   <= txBuf[0];
          txPos   <= 4'd1;
        end
        TX_DATA: if (txReady) begin
          if (txPos == txN) begin
            txState <= TX_SUM;
            txByte  <= 8'h00 - txSum; // R24
          end else begin
            txByte <= txBuf[txPos];
            txSum  <= txSum + txBuf[txPos];
            txPos  <= txPos + 4'd1;
          end
        end
        TX_SUM: if (txReady) begin
          txState <= TX_IDLE;
          txValid <= 1'b0;
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // Motor drive with anti-jam reversal and payout timeout
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {motorRun, motorReverse, jamTrip, timeoutTrip, ocCnt, revCnt, idleMs} <= '0;
    end else begin
      jamTrip     <= 1'b0;
      timeoutTrip <= 1'b0;
      if (!payoutActive || pfTrip) begin
        {motorRun, motorReverse, ocCnt, revCnt, idleMs} <= '0;
      end else if (motorReverse) begin
        motorRun <= 1'b0;
        if (msTick) revCnt <= revCnt + 9'd1;
        if (msTick && revCnt == 9'(REVERSE_MS - 1)) begin
          motorReverse <= 1'b0; // R19
          revCnt <= '0;
        end
      end else begin
        motorRun <= 1'b1;
        // Current must stay high on every ms sample without a break
        if (msTick) ocCnt <= overCurrent ? ocCnt + 9'd1 : '0; // R20
        if (msTick && overCurrent && ocCnt == 9'(OVERCUR_MS - 1) && !supplyLow) begin
          motorReverse <= 1'b1; // R19 R20
          motorRun <= 1'b0;
          jamTrip  <= 1'b1;
          ocCnt    <= '0;
        end
      end
      if (payoutActive && coinSeen) idleMs <= '0;
      else if (payoutActive && msTick) begin
        idleMs <= idleMs + 12'd1;
        timeoutTrip <= (idleMs == 12'(PAYOUT_TO_MS - 1));
      end
    end
  end

  // Supply watch: sampled each ms, trips once after 20 low samples
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {pfCnt, pfTrip, saveReq} <= '0;
    end else begin
      pfTrip  <= 1'b0;
      saveReq <= pfTrip; // R18
      if (msTick) begin
        pfCnt <= !supplyLow ? '0 : (pfCnt == 5'(PWRFAIL_MS)) ? pfCnt : pfCnt + 5'd1; // R23
        pfTrip <= supplyLow && pfCnt == 5'(PWRFAIL_MS - 1); // R18
      end
    end
  end

  // Register port; read data stands the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl     <= CTRL_RESET;
      {serialNo, pinCode, regRdata} <= '0;
    end else begin
      if (regWr) begin
        case (regAddr)
          REG_CTRL:   ctrl     <= {29'h0, regWdata[2:0]};
          REG_SERIAL: serialNo <= {8'h00, regWdata[23:0]};
          REG_PIN:    pinCode  <= regWdata;
          default: ;
        endcase
      end
      regRdata <= '0; // Read data stand one cycle only
      if (regRd) begin
        case (regAddr)
          REG_CTRL:   regRdata <= ctrl;
          REG_SERIAL: regRdata <= serialNo;
          REG_PIN:    regRdata <= pinCode;
          REG_STAT:   regRdata <= {5'h0, unlocked, enabled, payoutActive, eventCnt, coinsPaid, coinsLeft};
          default:    regRdata <= '0;
        endcase
      end
    end
  end

  a_test_reply: assert property (@(posedge clk) disable iff (!resetn) // R1
    cmdGo && rxHdr == CMD_TEST |=> txStart && txN == 4'd6) else $error("test reply length wrong");
  a_key_reply: assert property (@(posedge clk) disable iff (!resetn) // R6
    cmdGo && rxHdr == CMD_KEY_REQ |=> txBuf[1] == 8'd8 && keyFetched) else $error("key reply wrong");
  a_event_bump: assert property (@(posedge clk) disable iff (!resetn) // R11
    cmdGo && rxHdr == CMD_DISPENSE |=> eventCnt == $past(eventCnt) + 8'd1) else $error("event not bumped");
  a_busy_refuse: assert property (@(posedge clk) disable iff (!resetn) // R21
    cmdGo && rxHdr == CMD_DISPENSE && payoutActive |=> txBuf[3] == HDR_NAK) else $error("busy not refused");
  a_coin_count: assert property (@(posedge clk) disable iff (!resetn) // R22
    payoutActive && coinSeen |=> coinsPaid == $past(coinsPaid) + 8'd1 && coinsLeft == $past(coinsLeft) - 8'd1)
    else $error("coin count wrong");
  a_power_abort: assert property (@(posedge clk) disable iff (!resetn) // R18
    pfTrip |=> !payoutActive && !enabled && saveReq ##1 !motorRun && !saveReq) else $error("power fail not handled");
  a_jam_reverse: assert property (@(posedge clk) disable iff (!resetn) // R20
    jamTrip |-> motorReverse && !motorRun && $past(overCurrent)) else $error("reversal wrong");
  a_reply_sum: assert property (@(posedge clk) disable iff (!resetn) // R24
    txState == TX_SUM && txValid |-> 8'(txSum + txByte) == 8'h00) else $error("reply checksum bad");
endmodule : cps_sequencer

// *** inc/cps_pkg.sv ***
/*
  Constants shared by the coin payout command sequencer: frame layout, command
  headers, status bit positions, register map and timing counts.
  Assumes a 100 MHz system clock and a byte stream already deframed from the bus.
*/
package cps_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_TICK_CYC   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVERCUR_MS    = 160;  // Current above limit this long starts reversal
  localparam int REVERSE_MS    = 250;  // Motor reverse time
  localparam int PWRFAIL_MS    = 20;   // Supply below trip level this long aborts
  localparam int PAYOUT_TO_MS  = 2000; // No coin for this long ends the payout
  // Frame layout
  localparam int HDR_BYTES = 4;
  localparam int MAX_DATA  = 9;
  localparam int KEY_BYTES = 8;
  localparam int TX_MAX    = HDR_BYTES + KEY_BYTES;
  localparam logic [7:0] DEV_ADDR = 8'h03;
  // Command headers
  localparam logic [7:0] HDR_ACK      = 8'h00;
  localparam logic [7:0] HDR_NAK      = 8'h05;
  localparam logic [7:0] CMD_RESET    = 8'h01;
  localparam logic [7:0] CMD_KEY_REQ  = 8'hA0;
  localparam logic [7:0] CMD_RANDOM   = 8'hA1;
  localparam logic [7:0] CMD_TEST     = 8'hA3;
  localparam logic [7:0] CMD_ENABLE   = 8'hA4;
  localparam logic [7:0] ENABLE_CODE  = 8'hA5;
  localparam logic [7:0] CMD_STATUS   = 8'hA6;
  localparam logic [7:0] CMD_DISPENSE = 8'hA7;
  localparam logic [7:0] CMD_DISP_CNT = 8'hA8;
  localparam logic [7:0] CMD_PIN      = 8'hDA;
  localparam logic [7:0] CIPHER_MASK  = 8'h5A; // Arbitrary key transform
  // Keying modes
  typedef enum logic [1:0] {KEY_CIPHER, KEY_DUMMY, KEY_SERIAL} cps_keymode_t;
  // Test status bit positions
  localparam int ST0_EXPIRED  = 0;
  localparam int ST0_BLOCKAGE = 1;
  localparam int ST0_OPTO     = 2;
  localparam int ST0_DISABLED = 7;
  localparam int ST1_RESET    = 0;
  localparam int ST1_PIN_LOCK = 7;
  // Register map (word index)
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_SERIAL = 2'h1;
  localparam logic [1:0] REG_PIN    = 2'h2;
  localparam logic [1:0] REG_STAT   = 2'h3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
endpackage : cps_pkg

// *** test/cps_host_model.sv ***
/*
  Host controller model for the coin payout sequencer's frame link.
  Assumes one system clock; the bench calls its tasks one command at a time.
*/
`timescale 1ns/1ps
module cps_host_model (
  input  wire logic       clk,     // System clock
  input  wire logic       slow,    // Stretch the reply handshake
  output logic      [7:0] rxByte,  // Byte towards the device
  output logic            rxValid, // Byte strobe
  input  wire logic [7:0] txByte,  // Reply byte
  input  wire logic       txValid, // Reply byte offered
  output logic            txReady  // Reply byte taken
);
  import cps_pkg::*;

  // Idle link at time zero
  initial begin
    rxByte  = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b0;
  end

  // Whole frame, back to back bytes, zero-sum trailer
  task automatic send_frame(input logic [7:0] h, input int n, input logic [7:0] d [0:8]);
    logic [7:0] f [0:13];
    logic [7:0] s;
    f[0] = DEV_ADDR;
    f[1] = 8'(n);
    f[2] = 8'h01;
    f[3] = h;
    s = f[0] + f[1] + f[2] + f[3];
    for (int i = 0; i < n; i++) begin
      f[4 + i] = d[i];
      s = s + d[i];
    end
    f[4 + n] = 8'h00 - s;
    for (int i = 0; i <= 4 + n; i++) begin
      @(posedge clk);
      rxByte  <= f[i];
      rxValid <= 1'b1;
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte  <= ~f[4 + n]; // Released line must not keep the last byte
  endtask : send_frame

  // Reply bytes taken one per handshake; slow mode waits between them
  task automatic get_reply(output logic [7:0] r [0:15], output int cnt);
    int w;
    cnt = 0;
    w   = 0;
    while ((cnt < 5 || cnt < 5 + int'(r[1])) && w < 3000) begin
      @(posedge clk);
      w++;
      if (txValid === 1'b1 && txReady === 1'b1) begin
        r[cnt] = txByte;
        cnt++;
        txReady <= 1'b0;
      end else if (txValid === 1'b1 && (!slow || w % 4 == 0)) begin
        txReady <= 1'b1;
      end
    end
    // Timed out mid-handshake: drop ready one edge later
    if (cnt < 5 || cnt < 5 + int'(r[1])) begin
      @(posedge clk);
      txReady <= 1'b0;
    end
  endtask : get_reply
endmodule : cps_host_model

// *** test/tb_top.sv ***
/*
  Self-checking bench for the coin payout command sequencer.
  Assumes the host model on the frame link and the one-cycle register port.
*/
`timescale 1ns/1ps
module tb_top;
  import cps_pkg::*;
  logic        clk, resetn, regWr, regRd, coinSeen, optoBlocked, overCurrent, supplyLow, slowHost;
  logic        rxValid, txValid, txReady, motorRun, motorReverse, saveReq;
  logic [7:0]  rxByte, txByte;
  logic [1:0]  regAddr;
  logic [31:0] regWdata, regRdata, v;
  logic [7:0]  txd [0:8];
  logic [7:0]  rep [0:15];
  logic [7:0]  key [0:7];
  int          errors, checks_done, n;

  // Short ms tick keeps the long counts inside the run budget
  cps_sequencer #(.MS_CYCLES(10)) dut (
    .clk(clk), .resetn(resetn), .rxByte(rxByte), .rxValid(rxValid), .txByte(txByte),
    .txValid(txValid), .txReady(txReady), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .coinSeen(coinSeen),
    .optoBlocked(optoBlocked), .overCurrent(overCurrent), .supplyLow(supplyLow),
    .motorRun(motorRun), .motorReverse(motorReverse), .saveReq(saveReq));

  cps_host_model host (
    .clk(clk), .slow(slowHost), .rxByte(rxByte), .rxValid(rxValid),
    .txByte(txByte), .txValid(txValid), .txReady(txReady));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask : reg_rd

  // One command and its reply, framing checked on every reply
  task automatic cmd(input logic [7:0] h, input int nd, input logic [7:0] eh, input int el);
    int         cnt;
    logic [7:0] s;
    host.send_frame(h, nd, txd);
    host.get_reply(rep, cnt);
    check(cnt, 5 + el);
    s = 8'h00;
    for (int i = 0; i < cnt; i++) s = s + rep[i];
    check(s, 8'h00);
    check({rep[0], rep[1], rep[2], rep[3]}, {8'h01, 8'(el), DEV_ADDR, eh});
  endtask : cmd

  // Watchdog at about six times the expected run of 5000 cycles
  initial begin
    #300000;
    errors++;
    complete_run();
  end

  initial begin
    clk = 1'b0; resetn = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 2'h0; regWdata = 32'h0;
    coinSeen = 1'b0; optoBlocked = 1'b0; overCurrent = 1'b0; supplyLow = 1'b0; slowHost = 1'b0;
    errors = 0; checks_done = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, status word is read only
    reg_rd(REG_CTRL, v); check(v, CTRL_RESET);
    reg_wr(REG_STAT, 32'hFFFF_FFFF);
    reg_rd(REG_STAT, v); check(v, 32'h0);
    cmd(CMD_TEST, 0, HDR_ACK, 2); check({rep[4], rep[5]}, 16'h8081);
    for (int i = 0; i < 9; i++) txd[i] = 8'h11;
    cmd(CMD_DISPENSE, 9, HDR_NAK, 0);
    // Unlock after reset, then enable
    reg_wr(REG_PIN, 32'h1234_5678);
    txd[0] = 8'h78; txd[1] = 8'h56; txd[2] = 8'h34; txd[3] = 8'h12;
    cmd(CMD_PIN, 4, HDR_ACK, 0);
    txd[0] = ENABLE_CODE;
    cmd(CMD_ENABLE, 1, HDR_ACK, 0);
    cmd(CMD_TEST, 0, HDR_ACK, 2); check({rep[4], rep[5]}, 16'h0000);
    txd[0] = 8'hDA; txd[1] = 8'hAA; txd[2] = 8'h6F; txd[3] = 8'h9A;
    txd[4] = 8'h5D; txd[5] = 8'hC5; txd[6] = 8'h06; txd[7] = 8'h43;
    cmd(CMD_RANDOM, 8, HDR_ACK, 0);
    slowHost = 1'b1;
    cmd(CMD_KEY_REQ, 0, HDR_ACK, 8);
    slowHost = 1'b0;
    for (int i = 0; i < 8; i++) key[i] = rep[4 + i];
    // Unencrypted key is refused, transformed key pays three coins
    for (int i = 0; i < 8; i++) txd[i] = key[i];
    txd[8] = 8'h03;
    cmd(CMD_DISPENSE, 9, HDR_NAK, 0);
    for (int i = 0; i < 8; i++) txd[i] = key[i] ^ CIPHER_MASK;
    cmd(CMD_DISPENSE, 9, HDR_ACK, 1); check(rep[4], 8'h03);
    repeat (3) @(posedge clk);
    check(motorRun, 1'b1);
    cmd(CMD_DISPENSE, 9, HDR_NAK, 0);
    cmd(CMD_STATUS, 0, HDR_ACK, 4); check({rep[4], rep[5], rep[6], rep[7]}, 32'h0403_0000);
    repeat (3) begin
      @(posedge clk); coinSeen <= 1'b1;
      @(posedge clk); coinSeen <= 1'b0;
      repeat (20) @(posedge clk);
    end
    cmd(CMD_STATUS, 0, HDR_ACK, 4); check({rep[4], rep[5], rep[6], rep[7]}, 32'h0400_0300);
    reg_rd(REG_STAT, v); check(v, 32'h0604_0300);
    cmd(CMD_DISP_CNT, 0, HDR_ACK, 3); check({rep[6], rep[5], rep[4]}, 24'h00_0003);
    cmd(CMD_TEST, 0, HDR_ACK, 2); check({rep[4], rep[5]}, 16'h0000);
    // Serial keyed unit skips the key steps
    reg_wr(REG_CTRL, 32'h0000_0006);
    reg_wr(REG_SERIAL, 32'h000A_D7DF);
    txd[0] = 8'hDF; txd[1] = 8'hD7; txd[2] = 8'h0A; txd[3] = 8'h02;
    cmd(CMD_DISPENSE, 4, HDR_ACK, 1); check(rep[4], 8'h05);
    // Jam: overcurrent for 160 ms samples, then 250 ms reverse
    @(posedge clk); overCurrent <= 1'b1;
    n = 0;
    while (motorReverse !== 1'b1 && n < 1700) begin @(posedge clk); n++; end
    check(n >= 1585 && n <= 1615, 1'b1);
    check(motorRun, 1'b0);
    overCurrent <= 1'b0;
    n = 0;
    while (motorRun !== 1'b1 && n < 2700) begin @(posedge clk); n++; end
    check(n >= 2480 && n <= 2530, 1'b1);
    slowHost = 1'b1;
    cmd(CMD_TEST, 0, HDR_ACK, 2); check(rep[4] & 8'h02, 8'h02);
    slowHost = 1'b0;
    // Supply dip of 20 ms samples aborts and saves
    @(posedge clk); supplyLow <= 1'b1;
    n = 0;
    while (saveReq !== 1'b1 && n < 260) begin @(posedge clk); n++; end
    check(n >= 185 && n <= 215, 1'b1);
    supplyLow <= 1'b0;
    reg_rd(REG_STAT, v); check(v[25:24], 2'b00);
    check(motorRun | motorReverse, 1'b0);
    cmd(CMD_STATUS, 0, HDR_ACK, 4); check({rep[5], rep[7]}, 16'h0002);
    cmd(CMD_TEST, 0, HDR_ACK, 2); check({rep[4][7], rep[4][1], rep[5][7]}, 3'b111);
    // Host clears the error flags with a reset command
    cmd(CMD_RESET, 0, HDR_ACK, 0);
    cmd(CMD_TEST, 0, HDR_ACK, 2); check({rep[4], rep[5]}, 16'h8081);
    complete_run();
  end
endmodule : tb_top
